// *** pkg/rtcca_pkg.sv ***
// Shared constants and carrier types for the real-time clock counter block.
// Assumes one system clock; oscillator levels arrive already synchronous to it.
package rtcca_pkg;
   localparam int RTCCA_PRESC_W = 20;               // Prescaler width
   localparam int RTCCA_CNT_W = 32;                 // Main counter width
   localparam int RTCCA_HS_DIV_W = 5;               // Fast oscillator divider width
   localparam logic [4:0] RTCCA_HS_DIV_LAST = 5'h1F; // Divide by 32: last of 32 edges
   localparam logic [19:0] RTCCA_PRESC_1HZ = 20'h0_7FFF; // 32.768 kHz crystal gives 1 s
   localparam logic [19:0] RTCCA_PRESC_RST = 20'h0_0000;
   localparam logic [31:0] RTCCA_CNT_RST = 32'h0000_0000;
   localparam logic [4:0] RTCCA_HS_DIV_RST = 5'h00;
   localparam logic [2:0] RTCCA_OSC_RST = 3'h0;

   // Oscillator index inside the sampled source vector
   localparam int RTCCA_OSC_HS = 0;
   localparam int RTCCA_OSC_XT = 1;
   localparam int RTCCA_OSC_RC = 2;

   typedef enum logic [1:0] {
      RTCCA_SRC_HS_DIV = 2'h0,
      RTCCA_SRC_LS_XTAL = 2'h1,
      RTCCA_SRC_LS_RC = 2'h2
   } rtcca_src_t;

   // Control bundle from the owning subsystem
   typedef struct packed {
      rtcca_src_t src;
      logic [19:0] presc;
      logic [31:0] alarm;
      logic load;
      logic [31:0] load_val;
      logic stop_mode;
      logic sec_wake_en;
      logic alarm_wake_en;
   } rtcca_ctrl_t;

   // Event bundle, each bit a one-cycle pulse
   typedef struct packed {
      logic sec_irq;
      logic alarm_irq;
      logic wake;
   } rtcca_evt_t;
endpackage

// *** verilog/rtcca_prescaler.sv ***
// Programmable prescaler: divides source ticks by reload plus one.
// Assumes src_tick is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module rtcca_prescaler
   import rtcca_pkg::*;
#(
   parameter int PRESC_W = RTCCA_PRESC_W
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic src_tick,
   input wire logic restart,
   input wire logic [PRESC_W-1:0] reload,
   output logic tick
);
   // Refuse a prescaler with no bits
   if (PRESC_W < 1) begin : g_bad_w
      $error("rtcca_prescaler: PRESC_W must be at least 1");
   end

   logic [PRESC_W-1:0] cnt_r;
   logic [PRESC_W-1:0] cnt_nxt;
   logic tick_r;
   wire wrap_now = src_tick && (cnt_r == reload);

   // Reaching reload closes one period of reload plus one source ticks
   assign cnt_nxt = restart ? '0 : (wrap_now ? '0 : (src_tick ? cnt_r + 1'b1 : cnt_r)); // [R2] [R3]

   // Counter and registered tick
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_r <= wrap_now && !restart; // [R2]
      end
   end
   assign tick = tick_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   presc_tick_a: assert property (tick |-> $past(src_tick) && ($past(cnt_r) == $past(reload))) // [R3]
      else $error("prescaler tick without reaching reload");
   presc_quiet_a: assert property (!src_tick |=> !tick) // [R2]
      else $error("prescaler ticked without a source tick");
   presc_step_a: assert property (src_tick && !restart && (cnt_r != reload) |=> cnt_r == $past(cnt_r) + 1'b1) // [R2]
      else $error("prescaler did not advance on source tick");
endmodule

// *** verilog/rtcca_top.sv ***
// Real-time clock counter: source select, prescaler, 32-bit counter, alarm.
// Assumes oscillator levels are synchronous to clk_sys and much slower than it.
// What this block does
// [R1] Source: fast external divided 32, crystal, RC
// [R2] 20-bit prescaler makes the time-base tick
// [R3] Prescaler divides by its value plus one
// [R4] Loadable 32-bit counter increments each tick
// [R5] Alarm event when counter reaches alarm value
// [R6] Seconds interrupt per tick, alarm interrupt per match
// [R7] Runs in Stop; both events can wake
// [R8] Counter wraps from all ones to zero
`timescale 1ns/1ps
module rtcca_top
   import rtcca_pkg::*;
#(
   parameter int PRESC_W = RTCCA_PRESC_W
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic high_speed_external_osc,
   input wire logic low_speed_crystal_osc,
   input wire logic low_speed_internal_rc,
   input wire rtcca_ctrl_t ctrl,
   output logic [RTCCA_CNT_W-1:0] count,
   output rtcca_evt_t evt
);
   // Refuse widths the control bundle cannot carry
   if (PRESC_W < 1 || PRESC_W > RTCCA_PRESC_W) begin : g_bad_w
      $error("rtcca_top: PRESC_W out of range");
   end

   // Rising edge of a sampled level, shared by the three oscillator inputs
   function automatic logic rtcca_rise(input logic now, input logic prev);
      rtcca_rise = now && !prev;
   endfunction

   logic [2:0] osc_q_r;
   logic [RTCCA_HS_DIV_W-1:0] hs_div_r;
   logic [RTCCA_CNT_W-1:0] cnt_r;
   logic [RTCCA_CNT_W-1:0] cnt_nxt;
   rtcca_src_t src_q_r;
   rtcca_evt_t evt_r;
   rtcca_evt_t evt_nxt;
   wire [2:0] osc_now = {low_speed_internal_rc, low_speed_crystal_osc, high_speed_external_osc};
   wire [2:0] osc_rise;
   wire hs_div_tick;
   wire src_tick;
   wire base_tick;
   wire alarm_hit;
   wire src_change = (ctrl.src != src_q_r);

   // Edge detectors, one per oscillator
   // Samplers reset low, so a pin already high at release counts as one edge
   genvar gi;
   for (gi = 0; gi < $bits(osc_now); gi = gi + 1) begin : g_rise
      assign osc_rise[gi] = rtcca_rise(osc_now[gi], osc_q_r[gi]);
   end

   // Fast oscillator is reduced by 32 before it may drive the prescaler
   assign hs_div_tick = osc_rise[RTCCA_OSC_HS] && (hs_div_r == RTCCA_HS_DIV_LAST); // [R1]

   // Source select; a reserved code selects nothing so the clock stands still
   assign src_tick = (ctrl.src == RTCCA_SRC_HS_DIV) ? hs_div_tick :
                     (ctrl.src == RTCCA_SRC_LS_XTAL) ? osc_rise[RTCCA_OSC_XT] :
                     (ctrl.src == RTCCA_SRC_LS_RC) ? osc_rise[RTCCA_OSC_RC] : 1'b0; // [R1]

   // Sampling and divide-by-32 state
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         osc_q_r <= RTCCA_OSC_RST;
         hs_div_r <= RTCCA_HS_DIV_RST;
         src_q_r <= RTCCA_SRC_HS_DIV;
      end else begin
         osc_q_r <= osc_now;
         hs_div_r <= osc_rise[RTCCA_OSC_HS] ? hs_div_r + 1'b1 : hs_div_r; // [R1]
         src_q_r <= ctrl.src;
      end
   end

   // Restart the period on a source switch so a mixed-rate period never occurs
   rtcca_prescaler #(.PRESC_W(PRESC_W)) u_presc (
      .clk_sys(clk_sys),
      .rst(rst),
      .src_tick(src_tick),
      .restart(src_change),
      .reload(ctrl.presc[PRESC_W-1:0]),
      .tick(base_tick)
   ); // [R2]

   // Load wins over a tick in the same cycle; increment wraps naturally
   assign cnt_nxt = ctrl.load ? ctrl.load_val : (base_tick ? cnt_r + 1'b1 : cnt_r); // [R4] [R8]
   // Match is judged on the value the counter steps into
   // Loads never raise the alarm, so software may park the counter on the alarm value
   assign alarm_hit = base_tick && !ctrl.load && (cnt_nxt == ctrl.alarm); // [R5]

   // Events; stop mode gates nothing, it only enables the wake pulse
   // Interrupts still fire in Stop; wake is an extra pulse, not a substitute
   always_comb begin
      evt_nxt.sec_irq = base_tick; // [R6]
      evt_nxt.alarm_irq = alarm_hit; // [R6]
      evt_nxt.wake = ctrl.stop_mode && ((base_tick && ctrl.sec_wake_en) || (alarm_hit && ctrl.alarm_wake_en)); // [R7]
   end

   // Counter and event registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_r <= RTCCA_CNT_RST;
         evt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt; // [R4]
         evt_r <= evt_nxt;
      end
   end
   // Outputs come straight from the flip-flops
   assign count = cnt_r;
   assign evt = evt_r;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // Building blocks; a fresh rise is judged on the pins rather than on the samplers
   sequence hs_last_edge_s;
      (ctrl.src == RTCCA_SRC_HS_DIV) && !src_change && osc_rise[RTCCA_OSC_HS] && (hs_div_r == RTCCA_HS_DIV_LAST);
   endsequence

   sequence tick_no_load_s;
      base_tick && !ctrl.load;
   endsequence

   sequence xt_fresh_rise_s;
      low_speed_crystal_osc && !$past(low_speed_crystal_osc);
   endsequence

   sequence rc_fresh_rise_s;
      low_speed_internal_rc && !$past(low_speed_internal_rc);
   endsequence

   sequence hs_fresh_rise_s;
      high_speed_external_osc && !$past(high_speed_external_osc);
   endsequence

   // Tick whose step lands on the alarm value
   sequence alarm_step_s;
      tick_no_load_s ##0 (cnt_nxt == ctrl.alarm);
   endsequence

   // Tick taken while the device sits in Stop
   sequence stop_tick_s;
      ctrl.stop_mode ##0 tick_no_load_s;
   endsequence

   // Source selection: only the chosen oscillator may tick
   hs_div_tick_a: assert property (hs_last_edge_s |-> src_tick) // [R1]
      else $error("fast source edge 32 gave no source tick");
   hs_div_skip_a: assert property ((ctrl.src == RTCCA_SRC_HS_DIV) && (hs_div_r != RTCCA_HS_DIV_LAST) |-> !src_tick) // [R1]
      else $error("fast source ticked before 32 edges");
   hs_idle_a: assert property ((ctrl.src == RTCCA_SRC_HS_DIV) && !high_speed_external_osc |-> !src_tick) // [R1]
      else $error("fast source ticked with its pin low");
   xt_edge_a: assert property ((ctrl.src == RTCCA_SRC_LS_XTAL) ##0 xt_fresh_rise_s |-> src_tick) // [R1]
      else $error("crystal edge gave no source tick");
   xt_idle_a: assert property ((ctrl.src == RTCCA_SRC_LS_XTAL) && !low_speed_crystal_osc |-> !src_tick) // [R1]
      else $error("crystal source ticked with its pin low");
   rc_edge_a: assert property ((ctrl.src == RTCCA_SRC_LS_RC) ##0 rc_fresh_rise_s |-> src_tick) // [R1]
      else $error("RC edge gave no source tick");
   rc_idle_a: assert property ((ctrl.src == RTCCA_SRC_LS_RC) && !low_speed_internal_rc |-> !src_tick) // [R1]
      else $error("RC source ticked with its pin low");
   src_alone_a: assert property ((ctrl.src != RTCCA_SRC_LS_XTAL) && (ctrl.src != RTCCA_SRC_LS_RC) && !hs_div_tick |-> !src_tick) // [R1]
      else $error("unselected oscillator ticked");
   src_none_a: assert property (!(ctrl.src inside {RTCCA_SRC_HS_DIV, RTCCA_SRC_LS_XTAL, RTCCA_SRC_LS_RC}) |-> !src_tick) // [R1]
      else $error("reserved source code ticked");

   // Divide-by-32 counter moves only on fast edges; it runs whatever is selected
   hs_div_step_a: assert property (hs_fresh_rise_s |=> hs_div_r == $past(hs_div_r) + 1'b1) // [R1]
      else $error("fast edge not counted");
   hs_div_wrap_a: assert property (hs_fresh_rise_s ##0 (hs_div_r == RTCCA_HS_DIV_LAST) |=> hs_div_r == RTCCA_HS_DIV_RST) // [R1]
      else $error("divide by 32 did not wrap");
   hs_div_hold_a: assert property (!osc_rise[RTCCA_OSC_HS] |=> $stable(hs_div_r)) // [R1]
      else $error("fast divider moved without an edge");

   // Prescaler hand-over; a source switch costs the tick of that cycle
   presc_restart_a: assert property (src_change |=> !base_tick) // [R2]
      else $error("tick across a source switch");
   tick_src_a: assert property (base_tick |-> $past(src_tick)) // [R2]
      else $error("time-base tick without a source tick");

   // Counter; reset clears it whatever else is applied
   rst_clear_a: assert property (disable iff (1'b0) rst |=> (count == RTCCA_CNT_RST) && (evt == '0)) // [R4]
      else $error("reset left counter or events set");
   cnt_inc_a: assert property (tick_no_load_s |=> cnt_r == $past(cnt_r) + 1'b1) // [R4]
      else $error("counter did not step on tick");
   cnt_load_a: assert property (ctrl.load |=> cnt_r == $past(ctrl.load_val)) // [R4]
      else $error("counter load lost");
   cnt_hold_a: assert property (!base_tick && !ctrl.load |=> $stable(cnt_r)) // [R4]
      else $error("counter moved without tick");
   cnt_wrap_a: assert property (tick_no_load_s ##0 (&cnt_r) |=> cnt_r == RTCCA_CNT_RST) // [R8]
      else $error("counter failed to wrap");
   load_wins_a: assert property (base_tick && ctrl.load |=> (cnt_r == $past(ctrl.load_val)) && !evt.alarm_irq) // [R4]
      else $error("tick beat a load");

   // Alarm and seconds interrupts
   alarm_match_a: assert property (tick_no_load_s ##0 (cnt_r + 1'b1 == ctrl.alarm) |=> // [R5]
      evt.alarm_irq && count == $past(ctrl.alarm))
      else $error("alarm match missed");
   alarm_cause_a: assert property (evt.alarm_irq |-> // [R5]
      $past(base_tick) && !$past(ctrl.load) && (count == $past(ctrl.alarm)))
      else $error("alarm without a match");
   alarm_quiet_a: assert property (!base_tick |=> !evt.alarm_irq) // [R6]
      else $error("alarm interrupt without a tick");
   sec_irq_a: assert property (base_tick |=> evt.sec_irq) // [R6]
      else $error("seconds interrupt missed");
   sec_quiet_a: assert property (!base_tick |=> !evt.sec_irq) // [R6]
      else $error("seconds interrupt without a tick");

   // Stop mode: counting goes on, and wake needs an enabled event
   wake_sec_a: assert property (ctrl.stop_mode && ctrl.sec_wake_en && base_tick |=> evt.wake) // [R7]
      else $error("seconds wake missed");
   wake_alarm_a: assert property (ctrl.stop_mode && ctrl.alarm_wake_en ##0 alarm_step_s |=> evt.wake) // [R7]
      else $error("alarm wake missed");
   wake_cause_a: assert property (evt.wake |-> // [R7]
      $past(ctrl.stop_mode) && ((evt.sec_irq && $past(ctrl.sec_wake_en)) || (evt.alarm_irq && $past(ctrl.alarm_wake_en))))
      else $error("wake without an enabled event");
   wake_mask_a: assert property (!ctrl.sec_wake_en && !ctrl.alarm_wake_en |=> !evt.wake) // [R7]
      else $error("wake with both sources masked");
   wake_off_a: assert property (!ctrl.stop_mode |=> !evt.wake) // [R7]
      else $error("wake outside stop mode");
   stop_count_a: assert property (stop_tick_s |=> (cnt_r == $past(cnt_r) + 1'b1) && evt.sec_irq) // [R7]
      else $error("counter halted in stop mode");
endmodule

// *** testbench/rtcca_top_tb_top.sv ***
// Self-checking bench for the real-time clock counter top level.
// Assumes the bench drives oscillator levels and control directly, 1 ns after each rising edge.
`timescale 1ns/1ps
module rtcca_top_tb_top;
   import rtcca_pkg::*;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [2:0] osc = 3'h0;
   rtcca_ctrl_t ctrl = '0;
   logic [31:0] count;
   rtcca_evt_t evt;
   logic [31:0] n_sec = 32'h0000_0000;
   logic [31:0] n_alm = 32'h0000_0000;
   logic [31:0] n_wake = 32'h0000_0000;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;

   rtcca_top dut (.clk_sys(clk_sys), .rst(rst), .high_speed_external_osc(osc[RTCCA_OSC_HS]),
      .low_speed_crystal_osc(osc[RTCCA_OSC_XT]), .low_speed_internal_rc(osc[RTCCA_OSC_RC]),
      .ctrl(ctrl), .count(count), .evt(evt));

   // 200 MHz system clock
   initial forever #2.5 clk_sys = ~clk_sys;

   // Pulse counters; an unknown pulse poisons the count so it never matches
   always @(posedge clk_sys) begin
      if (!rst) begin
         n_sec <= n_sec + evt.sec_irq;
         n_alm <= n_alm + evt.alarm_irq;
         n_wake <= n_wake + evt.wake;
      end
   end

   // Hang guard; the one-second scenario alone needs about 65,550 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 70000) begin
         error_cnt++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // High one cycle, low one cycle per rise, then let the two-stage pipeline settle
   task automatic rise(input int idx, input int n);
      repeat (n) begin
         osc[idx] = 1'b1;
         cyc(1);
         osc[idx] = 1'b0;
         cyc(1);
      end
      cyc(3);
   endtask

   task automatic t_reset();
      chk(count, 32'h0000_0000);
      chk({29'h0, evt}, 32'h0000_0000);
   endtask

   // Each source in turn; unselected oscillators must not tick
   task automatic t_sources();
      ctrl.src = RTCCA_SRC_LS_XTAL;
      cyc(2);
      rise(RTCCA_OSC_XT, 3);
      chk(count, 32'h0000_0003);
      chk(n_sec, 32'h0000_0003);
      ctrl.src = RTCCA_SRC_LS_RC;
      cyc(2);
      rise(RTCCA_OSC_RC, 2);
      rise(RTCCA_OSC_XT, 1);
      chk(count, 32'h0000_0005);
      ctrl.src = RTCCA_SRC_HS_DIV;
      cyc(2);
      rise(RTCCA_OSC_HS, 31);
      chk(count, 32'h0000_0005);
      rise(RTCCA_OSC_HS, 1);
      chk(count, 32'h0000_0006);
   endtask

   // Reload 2 means one tick per three source ticks
   task automatic t_presc();
      ctrl.src = RTCCA_SRC_LS_XTAL;
      ctrl.presc = 20'h0_0002;
      cyc(2);
      rise(RTCCA_OSC_XT, 2);
      chk(count, 32'h0000_0006);
      rise(RTCCA_OSC_XT, 1);
      chk(count, 32'h0000_0007);
      ctrl.presc = 20'h0_0000;
      cyc(2);
   endtask

   task automatic t_load_alarm();
      ctrl.load = 1'b1;
      ctrl.load_val = 32'h1234_5678;
      ctrl.alarm = 32'h1234_5679;
      ctrl.stop_mode = 1'b1;
      ctrl.alarm_wake_en = 1'b1;
      cyc(1);
      ctrl.load = 1'b0;
      chk(count, 32'h1234_5678);
      rise(RTCCA_OSC_XT, 1);
      chk(n_alm, 32'h0000_0001);
      chk(n_wake, 32'h0000_0001);
      ctrl.sec_wake_en = 1'b1;
      ctrl.alarm_wake_en = 1'b0;
      rise(RTCCA_OSC_XT, 1);
      chk(n_wake, 32'h0000_0002);
      chk(n_alm, 32'h0000_0001);
      ctrl.stop_mode = 1'b0;
      rise(RTCCA_OSC_XT, 1);
      chk(n_wake, 32'h0000_0002);
      chk(n_sec, 32'h0000_000A);
   endtask

   // All ones steps to zero and still matches an alarm of zero
   task automatic t_wrap();
      ctrl.load = 1'b1;
      ctrl.load_val = 32'hFFFF_FFFF;
      ctrl.alarm = 32'h0000_0000;
      cyc(1);
      ctrl.load = 1'b0;
      rise(RTCCA_OSC_XT, 1);
      chk(count, 32'h0000_0000);
      chk(n_alm, 32'h0000_0002);
   endtask

   // A tick that meets a load is dropped and raises no alarm
   task automatic t_load_tick();
      osc[RTCCA_OSC_XT] = 1'b1;
      cyc(1);
      ctrl.load = 1'b1;
      ctrl.load_val = 32'h0000_0040;
      ctrl.alarm = 32'h0000_0040;
      cyc(1);
      ctrl.load = 1'b0;
      osc[RTCCA_OSC_XT] = 1'b0;
      cyc(3);
      chk(count, 32'h0000_0040);
      chk(n_alm, 32'h0000_0002);
   endtask

   // The reserved source code stops the clock, whatever the oscillators do
   task automatic t_stopped();
      logic [31:0] sec_before;
      sec_before = n_sec;
      ctrl.src = rtcca_src_t'(2'h3);
      cyc(2);
      rise(RTCCA_OSC_HS, 32);
      rise(RTCCA_OSC_XT, 1);
      rise(RTCCA_OSC_RC, 1);
      chk(count, 32'h0000_0040);
      chk(n_sec, sec_before);
   endtask

   // Crystal with reload 7FFF: one tick after exactly 32768 crystal edges
   task automatic t_one_sec();
      ctrl.src = RTCCA_SRC_LS_XTAL;
      ctrl.presc = RTCCA_PRESC_1HZ;
      cyc(2);
      rise(RTCCA_OSC_XT, int'(RTCCA_PRESC_1HZ));
      chk(count, 32'h0000_0040);
      rise(RTCCA_OSC_XT, 1);
      chk(count, 32'h0000_0041);
      ctrl.presc = RTCCA_PRESC_RST;
      cyc(2);
   endtask

   // Mid-run reset clears the outputs, and counting resumes afterwards
   task automatic t_rerun();
      rst = 1'b1;
      cyc(2);
      chk(count, 32'h0000_0000);
      chk({29'h0, evt}, 32'h0000_0000);
      rst = 1'b0;
      cyc(2);
      rise(RTCCA_OSC_XT, 1);
      chk(count, 32'h0000_0001);
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      t_reset();
      t_sources();
      t_presc();
      t_load_alarm();
      t_wrap();
      t_load_tick();
      t_stopped();
      t_one_sec();
      t_rerun();
      print_verdict();
   end
endmodule
